// ---- logic/acc_pkg.sv ----
// Package for the accumulator input control block.
// Assumes a single 100 MHz clock; timing pulses arrive as one-cycle strobes.
package acc_pkg;

    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int WORD_W = 16;
    localparam int CHAR_W = 8;
    localparam logic [15:0] ACC_RESET = 16'h0000;
    localparam logic [15:0] PARITY_ONE = 16'h0001;
    localparam logic [7:0] FUNC_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Instruction field positions and codes
    // ------------------------------------------------------------------
    localparam int OPC_HI = 15;
    localparam int OPC_LO = 12;
    localparam int SUB_HI = 11;
    localparam int SUB_LO = 8;
    localparam logic [3:0] OPC_REGREF = 4'h0;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int SETTLE_NS = 50;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SHORT_ADV_NS = 100;
    localparam int SHORT_ADV_CYC = SHORT_ADV_NS / CLK_PERIOD_NS;

    // Sequencer timing strobes
    typedef struct packed {
        logic cycle_start_pulse;
        logic quarter_phase_pulse;
        logic half_phase_pulse;
        logic early_set_pulse;
        logic mid_set_pulse;
        logic late_set_pulse;
    } timing_s;

    // Minor cycle and mode qualifiers
    typedef struct packed {
        logic a_cycle;
        logic b_cycle;
        logic c_cycle;
        logic read_operand_mode;
        logic register_operand_mode;
        logic store_mode;
        logic next_instr_read;
        logic short_cycle_one;
    } phase_s;

    // Instruction class decode
    typedef struct packed {
        logic reg_ref;
        logic multiply;
        logic divide;
        logic load_accumulator_instr;
        logic add;
        logic subtract;
        logic logical_and;
        logic exclusive_or_instr;
        logic store_parity_instr;
        logic input_word_instr;
        logic enter_accumulator_instr;
        logic increase_accumulator_instr;
        logic inter_register_instr;
        logic shift;
    } iclass_s;

    typedef enum logic [2:0] {
        SRC_NONE = 3'b001,
        SRC_ADDER = 3'b010,
        SRC_INPUT = 3'b100
    } src_e;

endpackage : acc_pkg

// ---- logic/acc_decode.sv ----
// Function register and instruction class decoder.
// Assumes the fetched word is stable at the quarter phase of a next-instruction read.
module acc_decode (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic capture,
    input wire logic [15:0] fetched_word,
    output acc_pkg::iclass_s iclass
);
    logic [7:0] func_reg;
    logic [3:0] opc;
    logic [3:0] sub;
    logic rr;

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            func_reg <= acc_pkg::FUNC_RESET;
        end else if (capture) begin
            func_reg <= fetched_word[acc_pkg::OPC_HI:acc_pkg::SUB_LO];
        end
    end

    assign opc = func_reg[7:4];
    assign sub = func_reg[3:0];
    assign rr = (opc == acc_pkg::OPC_REGREF);

    assign iclass.reg_ref = rr;
    assign iclass.multiply = (opc == 4'h2);
    assign iclass.divide = (opc == 4'h3);
    assign iclass.store_parity_instr = (opc == 4'h7);
    assign iclass.add = (opc == 4'h8);
    assign iclass.subtract = (opc == 4'h9);
    assign iclass.logical_and = (opc == 4'hA);
    assign iclass.exclusive_or_instr = (opc == 4'hB);
    assign iclass.load_accumulator_instr = (opc == 4'hC);
    assign iclass.input_word_instr = rr && (sub == 4'h2);
    assign iclass.inter_register_instr = rr && (sub == 4'h8);
    assign iclass.increase_accumulator_instr = rr && (sub == 4'h9);
    assign iclass.enter_accumulator_instr = rr && (sub == 4'hA);
    assign iclass.shift = rr && (sub == 4'hF);
endmodule : acc_decode

// ---- logic/acc_input_control.sv ----
// Accumulator register with its input-selection control.
// Assumes timing strobes from the sequencer are one-cycle pulses on MCLK,
// and that the adder/shifter result is valid at each cycle_start_pulse.
//
// Summary of operation
// - Multiply: multiplier in, low product out
// - Divide: low dividend in, quotient out
// - Two selects pick adder, word, low-speed
// - Accumulator feeds adder operand path
// - Adder select set half phase before load
// - Quarter phase clears adder select unless a set is present
// - Manual console selection sets adder select when ACC_TO_ADDER
// - Accumulator shift: early, late set if count
// - Short cycle advances late set pulse
// - Combined shift: set only at late
// - Mul/div read operand B late set
// - Mid set loads product or dividend
// - Enter/increase set at A late
// - Inter-register with destination A bit
// - Load/arith/logic set at B late
// - Store parity loads +1 if even
// - Word mode loads full input word
// - Character mode loads low byte only
// - Input select set unless device refuses
// - Zero top nibble means register reference
// - Quarter phase copies high byte to function
module acc_input_control (
    input wire logic MCLK,
    input wire logic RST,
    input acc_pkg::timing_s TIMING,
    input acc_pkg::phase_s PHASE,
    input wire logic [15:0] FETCHED_WORD,
    input wire logic [15:0] ADDER_RESULT,
    input wire logic [15:0] WORD_RX,
    input wire logic [15:0] LOWSPEED_RX,
    input wire logic LOWSPEED_SEL,
    input wire logic CHAR_MODE,
    input wire logic DEVICE_REFUSE,
    input wire logic [7:0] SHIFT_COUNT,
    input wire logic SHIFT_A_ONLY,
    input wire logic SHIFT_AQ,
    input wire logic DESTINATION_A_BIT,
    input wire logic PARITY_BIT,
    input wire logic ACC_NEGATIVE,
    input wire logic MANUAL_ACC_SEL,
    input wire logic ACC_TO_ADDER,
    input wire logic MASTER_CLEAR,
    output logic [15:0] ACC_OUT,
    output logic [15:0] ADDER_OPERAND,
    output logic ADDER_TO_ACC_SELECT,
    output logic INPUT_TO_ACC_SELECT,
    output logic [2:0] ACC_SOURCE
);
    acc_pkg::iclass_s iclass;
    logic [15:0] acc_reg;
    logic [15:0] acc_next;
    logic adder_sel_reg;
    logic input_sel_reg;
    logic [15:0] rx_word;
    logic [15:0] input_word;
    logic count_nonzero;
    logic set_shift;
    logic set_muldiv;
    logic set_reg_op;
    logic set_load;
    logic set_parity;
    logic set_manual;
    logic set_adder;
    logic set_input;
    logic arm_pulse;
    acc_pkg::src_e src;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    acc_decode u_decode (
        .MCLK(MCLK),
        .RST(RST),
        .capture(TIMING.quarter_phase_pulse && PHASE.next_instr_read),
        .fetched_word(FETCHED_WORD),
        .iclass(iclass)
    );

    // ------------------------------------------------------------------
    // Set conditions for the adder and input selects
    // ------------------------------------------------------------------
    // Sequencer delivers late_set_pulse already advanced during short_cycle_one.
    // short cycle late set
    assign arm_pulse = TIMING.late_set_pulse;
    assign count_nonzero = (SHIFT_COUNT != 8'h00);

    assign set_shift = iclass.shift && PHASE.c_cycle && count_nonzero
        && ((SHIFT_A_ONLY && ACC_TO_ADDER && (TIMING.early_set_pulse || arm_pulse))
        || (SHIFT_AQ && arm_pulse));

    assign set_muldiv = (iclass.multiply || iclass.divide) && PHASE.read_operand_mode
        && ((PHASE.b_cycle && arm_pulse) || (PHASE.c_cycle && TIMING.mid_set_pulse));

    assign set_reg_op = PHASE.a_cycle && arm_pulse
        && ((PHASE.register_operand_mode
        && (iclass.enter_accumulator_instr || iclass.increase_accumulator_instr))
        || (iclass.inter_register_instr && DESTINATION_A_BIT));

    assign set_load = PHASE.b_cycle && arm_pulse && (iclass.load_accumulator_instr
        || iclass.add || iclass.subtract || iclass.logical_and
        || iclass.exclusive_or_instr);

    assign set_parity = iclass.store_parity_instr && PHASE.a_cycle && PHASE.store_mode
        && arm_pulse && PARITY_BIT;

    assign set_manual = MANUAL_ACC_SEL && ACC_TO_ADDER;

    assign set_adder = set_shift || set_muldiv || set_reg_op || set_load
        || set_parity || set_manual;

    assign set_input = iclass.input_word_instr && PHASE.a_cycle && arm_pulse
        && !DEVICE_REFUSE;

    // ------------------------------------------------------------------
    // Select flip-flops
    // ------------------------------------------------------------------
    // Set wins over the quarter-phase clear so a coincident event is kept.
    // set ahead of load
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            adder_sel_reg <= 1'b0;
            input_sel_reg <= 1'b0;
        end else begin
            adder_sel_reg <= set_adder || (adder_sel_reg && !TIMING.quarter_phase_pulse);
            input_sel_reg <= set_input || (input_sel_reg && !TIMING.quarter_phase_pulse);
        end
    end

    // ------------------------------------------------------------------
    // Accumulator input multiplexer
    // ------------------------------------------------------------------
    // three-way source select
    assign rx_word = LOWSPEED_SEL ? LOWSPEED_RX : WORD_RX;
    assign input_word = CHAR_MODE ? {acc_reg[15:8], rx_word[7:0]} : rx_word;
    assign src = adder_sel_reg ? acc_pkg::SRC_ADDER
        : (input_sel_reg ? acc_pkg::SRC_INPUT : acc_pkg::SRC_NONE);

    always_comb begin
        acc_next = acc_reg;
        case (src)
            acc_pkg::SRC_ADDER: begin
                acc_next = ADDER_RESULT;
            end
            acc_pkg::SRC_INPUT: begin
                acc_next = input_word;
            end
            acc_pkg::SRC_NONE: begin
                acc_next = acc_reg;
            end
            default: begin
                acc_next = acc_reg;
            end
        endcase
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            acc_reg <= acc_pkg::ACC_RESET;
        end else if (MASTER_CLEAR) begin
            acc_reg <= acc_pkg::ACC_RESET;
        end else if (TIMING.cycle_start_pulse) begin
            acc_reg <= acc_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // operand fan-out
    assign ADDER_OPERAND = acc_reg;
    assign ACC_OUT = acc_reg;
    assign ADDER_TO_ACC_SELECT = adder_sel_reg;
    assign INPUT_TO_ACC_SELECT = input_sel_reg;
    assign ACC_SOURCE = src;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_load_sel;
        adder_sel_reg && TIMING.cycle_start_pulse && !MASTER_CLEAR;
    endsequence

    a_quarter_clear: assert property (@(posedge MCLK) disable iff (RST)
        TIMING.quarter_phase_pulse && !set_adder |=> !adder_sel_reg)
        else $error("adder select not cleared at quarter phase");
    a_adder_load: assert property (@(posedge MCLK) disable iff (RST)
        s_load_sel |=> acc_reg == $past(ADDER_RESULT))
        else $error("accumulator missed adder load");
    a_hold_value: assert property (@(posedge MCLK) disable iff (RST)
        !TIMING.cycle_start_pulse && !MASTER_CLEAR |=> $stable(acc_reg))
        else $error("accumulator changed without load");
    a_clear_zero: assert property (@(posedge MCLK) disable iff (RST)
        MASTER_CLEAR |=> acc_reg == acc_pkg::ACC_RESET)
        else $error("master clear did not zero accumulator");
    a_refuse_block: assert property (@(posedge MCLK) disable iff (RST)
        DEVICE_REFUSE && !input_sel_reg |=> !input_sel_reg)
        else $error("input select set despite refusal");
    a_char_high: assert property (@(posedge MCLK) disable iff (RST)
        TIMING.cycle_start_pulse && input_sel_reg && !adder_sel_reg && CHAR_MODE
        && !MASTER_CLEAR |=> acc_reg[15:8] == $past(acc_reg[15:8]))
        else $error("character mode changed high byte");
    a_word_load: assert property (@(posedge MCLK) disable iff (RST)
        TIMING.cycle_start_pulse && input_sel_reg && !adder_sel_reg && !CHAR_MODE
        && !MASTER_CLEAR |=> acc_reg == $past(rx_word))
        else $error("word mode load wrong");
    a_manual_set: assert property (@(posedge MCLK) disable iff (RST)
        MANUAL_ACC_SEL && ACC_TO_ADDER |=> adder_sel_reg)
        else $error("manual selection did not set adder select");
    a_zero_count: assert property (@(posedge MCLK) disable iff (RST)
        iclass.shift && SHIFT_COUNT == 8'h00 && !set_manual |-> !set_shift)
        else $error("shift set with zero count");
    a_fanout_path: assert property (@(posedge MCLK) disable iff (RST)
        ADDER_OPERAND == acc_reg)
        else $error("operand path differs from accumulator");

    // ------------------------------------------------------------------
    // Set and decode checks
    // ------------------------------------------------------------------
    // Each sequence but s_aq_early and s_fetch_capture spells out a whole set condition, so a term dropped
    // from the set logic shows up as a select that never rises.
    sequence s_shift_early;
        iclass.shift && PHASE.c_cycle && SHIFT_A_ONLY && ACC_TO_ADDER && count_nonzero
        && TIMING.early_set_pulse;
    endsequence
    sequence s_aq_early;
        iclass.shift && SHIFT_AQ && !SHIFT_A_ONLY && !set_manual
        && TIMING.early_set_pulse && !TIMING.late_set_pulse;
    endsequence
    sequence s_muldiv_b;
        (iclass.multiply || iclass.divide) && PHASE.read_operand_mode && PHASE.b_cycle
        && TIMING.late_set_pulse;
    endsequence
    sequence s_muldiv_mid;
        (iclass.multiply || iclass.divide) && PHASE.read_operand_mode && PHASE.c_cycle
        && TIMING.mid_set_pulse;
    endsequence
    sequence s_enter_incr;
        (iclass.enter_accumulator_instr || iclass.increase_accumulator_instr)
        && PHASE.register_operand_mode && PHASE.a_cycle && TIMING.late_set_pulse;
    endsequence
    sequence s_inter_dest;
        iclass.inter_register_instr && DESTINATION_A_BIT && PHASE.a_cycle
        && TIMING.late_set_pulse;
    endsequence
    sequence s_b_result;
        (iclass.load_accumulator_instr || iclass.add || iclass.subtract
        || iclass.logical_and || iclass.exclusive_or_instr) && PHASE.b_cycle
        && TIMING.late_set_pulse;
    endsequence
    sequence s_parity_even;
        iclass.store_parity_instr && PHASE.store_mode && PHASE.a_cycle && PARITY_BIT
        && TIMING.late_set_pulse;
    endsequence
    sequence s_input_accept;
        iclass.input_word_instr && PHASE.a_cycle && !DEVICE_REFUSE
        && TIMING.late_set_pulse;
    endsequence
    sequence s_fetch_capture;
        TIMING.quarter_phase_pulse && PHASE.next_instr_read;
    endsequence

    a_shift_early: assert property (@(posedge MCLK) disable iff (RST)
        s_shift_early |=> adder_sel_reg)
        else $error("accumulator shift missed early set");
    a_aq_no_early: assert property (@(posedge MCLK) disable iff (RST)
        s_aq_early |-> !set_adder)
        else $error("combined shift set at early pulse");
    a_muldiv_late: assert property (@(posedge MCLK) disable iff (RST)
        s_muldiv_b |=> adder_sel_reg)
        else $error("multiply or divide missed B cycle set");
    a_muldiv_mid: assert property (@(posedge MCLK) disable iff (RST)
        s_muldiv_mid |=> adder_sel_reg)
        else $error("multiply or divide missed mid set");
    a_enter_incr: assert property (@(posedge MCLK) disable iff (RST)
        s_enter_incr |=> adder_sel_reg)
        else $error("enter or increase missed A cycle set");
    a_inter_dest: assert property (@(posedge MCLK) disable iff (RST)
        s_inter_dest |=> adder_sel_reg)
        else $error("inter-register missed accumulator destination");
    a_result_load: assert property (@(posedge MCLK) disable iff (RST)
        s_b_result |=> adder_sel_reg)
        else $error("arithmetic result missed B cycle set");
    a_parity_one: assert property (@(posedge MCLK) disable iff (RST)
        s_parity_even |=> adder_sel_reg)
        else $error("store parity missed set on even parity");
    a_input_set: assert property (@(posedge MCLK) disable iff (RST)
        s_input_accept |=> input_sel_reg)
        else $error("input select not set for accepted input");
    a_input_clear: assert property (@(posedge MCLK) disable iff (RST)
        TIMING.quarter_phase_pulse && !set_input |=> !input_sel_reg)
        else $error("input select not cleared at quarter phase");
    a_char_low: assert property (@(posedge MCLK) disable iff (RST)
        TIMING.cycle_start_pulse && input_sel_reg && !adder_sel_reg && CHAR_MODE
        && !MASTER_CLEAR |=> acc_reg[7:0] == $past(rx_word[7:0]))
        else $error("character mode low byte load wrong");
    a_regref_decode: assert property (@(posedge MCLK) disable iff (RST)
        s_fetch_capture |=> iclass.reg_ref
        == ($past(FETCHED_WORD[acc_pkg::OPC_HI:acc_pkg::OPC_LO]) == acc_pkg::OPC_REGREF))
        else $error("register reference decode wrong");
    a_func_capture: assert property (@(posedge MCLK) disable iff (RST)
        s_fetch_capture |=> iclass.shift == ($past(FETCHED_WORD[15:8]) == 8'h0F))
        else $error("function register missed fetched high byte");
endmodule : acc_input_control

// ---- tb/far_side_model.sv ----
// Far-side model: adder/shifter result path and the two input receivers.
// Assumes the accumulator operand is a level and the receiver choice is held by the bench.
module far_side_model #(
    parameter logic [15:0] WORD_DATA = 16'hA5C3,
    parameter logic [15:0] LOW_DATA = 16'h3C96
) (
    input wire logic MCLK,
    input wire logic [15:0] operand,
    input wire logic lowspeed_sel,
    output logic [15:0] adder_result,
    output logic [15:0] word_rx,
    output logic [15:0] lowspeed_rx
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] churn_reg = 16'h0000;
    always_ff @(posedge MCLK) begin
        churn_reg <= churn_reg + 16'h1357;
    end
    assign adder_result = operand + 16'h0001;
    // Unselected receiver churns so a wrong pick never matches stale data
    assign word_rx = lowspeed_sel ? churn_reg : WORD_DATA;
    assign lowspeed_rx = lowspeed_sel ? LOW_DATA : ~churn_reg;
endmodule : far_side_model

// ---- tb/tb.sv ----
// Self-checking bench for the accumulator input control.
// Assumes a 100 MHz MCLK; inputs change at the falling edge.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    localparam logic [15:0] WDATA = 16'hA5C3;
    localparam logic [15:0] LDATA = 16'h3C96;
    logic mclk = 1'h0;
    logic rst = 1'h1;
    acc_pkg::timing_s timing = '0;
    acc_pkg::phase_s phase = '0;
    logic [15:0] fetched = 16'h0000;
    logic [15:0] adder_result, word_rx, lowspeed_rx, acc_out, operand;
    logic low_sel = 1'h0, char_mode = 1'h0, refuse = 1'h0, a_only = 1'h0, aq = 1'h0;
    logic dest_a = 1'h0, parity = 1'h0, manual = 1'h0, mclear = 1'h0, a_to_add = 1'h0;
    logic [7:0] count = 8'h00;
    logic add_sel, in_sel;
    logic [2:0] source;
    logic [15:0] acc_m = 16'h0000;
    int n_fail = 0;
    int checks = 0;
    int cycles = 0;

    acc_input_control DUT (.MCLK(mclk), .RST(rst), .TIMING(timing), .PHASE(phase),
        .FETCHED_WORD(fetched), .ADDER_RESULT(adder_result), .WORD_RX(word_rx),
        .LOWSPEED_RX(lowspeed_rx), .LOWSPEED_SEL(low_sel), .CHAR_MODE(char_mode),
        .DEVICE_REFUSE(refuse), .SHIFT_COUNT(count), .SHIFT_A_ONLY(a_only), .SHIFT_AQ(aq),
        .DESTINATION_A_BIT(dest_a), .PARITY_BIT(parity), .ACC_NEGATIVE(1'h0),
        .MANUAL_ACC_SEL(manual), .ACC_TO_ADDER(a_to_add), .MASTER_CLEAR(mclear),
        .ACC_OUT(acc_out), .ADDER_OPERAND(operand), .ADDER_TO_ACC_SELECT(add_sel),
        .INPUT_TO_ACC_SELECT(in_sel), .ACC_SOURCE(source));
    far_side_model #(.WORD_DATA(WDATA), .LOW_DATA(LDATA)) far (.MCLK(mclk),
        .operand(operand), .lowspeed_sel(low_sel), .adder_result(adder_result),
        .word_rx(word_rx), .lowspeed_rx(lowspeed_rx));

    initial begin
        forever #5 mclk = ~mclk;
    end
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            finish_test();
        end
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic fetch(input logic [15:0] w);
        @(negedge mclk);
        fetched = w;
        phase = 8'h02;
        timing = 6'h10;
        @(negedge mclk);
        phase = '0;
        timing = '0;
    endtask : fetch
    // Set pulse, select check, load, then quarter-phase clear
    task automatic run(input logic [5:0] setp, input logic [7:0] ph, input logic m,
        input logic ea, input logic ei);
        logic [15:0] rx;
        logic [2:0] src;
        rx = low_sel ? LDATA : WDATA;
        src = ea ? acc_pkg::SRC_ADDER : (ei ? acc_pkg::SRC_INPUT : acc_pkg::SRC_NONE);
        @(negedge mclk);
        timing = setp;
        phase = ph;
        manual = m;
        @(negedge mclk);
        manual = 1'h0;
        check({11'h000, add_sel, in_sel, source}, {11'h000, ea, ei, src});
        timing = 6'h20;
        @(negedge mclk);
        if (ea) begin
            acc_m = acc_m + 16'h0001;
        end else if (ei) begin
            acc_m = char_mode ? {acc_m[15:8], rx[7:0]} : rx;
        end
        check(acc_out, acc_m);
        check(operand, acc_m);
        timing = 6'h10;
        @(negedge mclk);
        timing = '0;
        phase = '0;
        check({14'h0000, add_sel, in_sel}, 16'h0000);
    endtask : run
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_enter();
        fetch(16'h0A00);
        run(6'h01, 8'h88, 1'h0, 1'h1, 1'h0);
        fetch(16'h0900);
        run(6'h01, 8'h88, 1'h0, 1'h1, 1'h0);
        run(6'h01, 8'h80, 1'h0, 1'h0, 1'h0);
        fetch(16'h1A00);
        run(6'h01, 8'h88, 1'h0, 1'h0, 1'h0);
    endtask : t_enter
    task automatic t_load();
        for (logic [3:0] op = 4'h8; op <= 4'hC; op++) begin
            fetch({op, 12'h000});
            run(6'h01, 8'h40, 1'h0, 1'h1, 1'h0);
        end
        run(6'h01, 8'h80, 1'h0, 1'h0, 1'h0);
    endtask : t_load
    task automatic t_shift();
        fetch(16'h0F00);
        a_only = 1'h1;
        a_to_add = 1'h1;
        count = 8'h03;
        run(6'h04, 8'h20, 1'h0, 1'h1, 1'h0);
        run(6'h01, 8'h20, 1'h0, 1'h1, 1'h0);
        run(6'h01, 8'h21, 1'h0, 1'h1, 1'h0);
        count = 8'h00;
        run(6'h04, 8'h20, 1'h0, 1'h0, 1'h0);
        a_only = 1'h0;
        a_to_add = 1'h0;
        aq = 1'h1;
        count = 8'h01;
        run(6'h04, 8'h20, 1'h0, 1'h0, 1'h0);
        run(6'h01, 8'h20, 1'h0, 1'h1, 1'h0);
        aq = 1'h0;
    endtask : t_shift
    task automatic t_muldiv();
        fetch(16'h2000);
        run(6'h01, 8'h50, 1'h0, 1'h1, 1'h0);
        run(6'h02, 8'h30, 1'h0, 1'h1, 1'h0);
        fetch(16'h3000);
        run(6'h02, 8'h30, 1'h0, 1'h1, 1'h0);
    endtask : t_muldiv
    task automatic t_inter();
        fetch(16'h0800);
        dest_a = 1'h1;
        run(6'h01, 8'h80, 1'h0, 1'h1, 1'h0);
        dest_a = 1'h0;
        run(6'h01, 8'h80, 1'h0, 1'h0, 1'h0);
    endtask : t_inter
    task automatic t_parity();
        mclear = 1'h1;
        @(negedge mclk);
        mclear = 1'h0;
        acc_m = 16'h0000;
        check(acc_out, acc_pkg::ACC_RESET);
        fetch(16'h7000);
        parity = 1'h1;
        run(6'h01, 8'h84, 1'h0, 1'h1, 1'h0);
        check(acc_out, acc_pkg::PARITY_ONE);
        parity = 1'h0;
        run(6'h01, 8'h84, 1'h0, 1'h0, 1'h0);
    endtask : t_parity
    task automatic t_input();
        fetch(16'h0200);
        run(6'h01, 8'h80, 1'h0, 1'h0, 1'h1);
        low_sel = 1'h1;
        run(6'h01, 8'h80, 1'h0, 1'h0, 1'h1);
        low_sel = 1'h0;
        char_mode = 1'h1;
        run(6'h01, 8'h80, 1'h0, 1'h0, 1'h1);
        refuse = 1'h1;
        run(6'h01, 8'h80, 1'h0, 1'h0, 1'h0);
        refuse = 1'h0;
        char_mode = 1'h0;
        low_sel = 1'h0;
        run(6'h00, 8'h00, 1'h1, 1'h0, 1'h0);
        a_to_add = 1'h1;
        run(6'h00, 8'h00, 1'h1, 1'h1, 1'h0);
        a_to_add = 1'h0;
    endtask : t_input
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(negedge mclk);
        rst = 1'h0;
        check({11'h000, add_sel, in_sel, source}, {13'h0000, acc_pkg::SRC_NONE});
        check(acc_out, acc_pkg::ACC_RESET);
        t_enter();
        t_load();
        t_shift();
        t_muldiv();
        t_inter();
        t_parity();
        t_input();
        finish_test();
    end
endmodule : tb
